//--- dtbx_pkg.sv
// Behaviour
// - extended program read loads r0 from page:third pointer, 3 cycles, flags kept
// - post-increment load reads at pointer then increments it, 2 cycles, flags kept
// - pre-decrement load decrements pointer then reads at new value, 2 cycles
// - offset load reads pointer plus displacement, pointer kept, 2 cycles
// - absolute load reads byte at instruction address, 2 cycles, flags kept
// - post-increment write stores at pointer then increments it, 2 cycles
// - pre-decrement write decrements pointer then stores there, 2 cycles
// - offset write stores at pointer plus displacement, pointer kept, 2 cycles
// - absolute write stores source at instruction address, 2 cycles, flags kept
// - push writes source onto stack and moves stack pointer, 2 cycles
// - pop returns top stack byte and moves stack pointer, 2 cycles
// - io bit set forces one io bit high, others kept, 2 cycles
// - io bit clear forces one io bit low, others kept, 2 cycles
// - rotate left through carry, updates Z C N V, 1 cycle
// - rotate right through carry, updates Z C N V, 1 cycle
// - bit to transfer flag copies source bit into T, 1 cycle
// - transfer flag to bit copies T into destination bit, 1 cycle
package dtbx_pkg;
	localparam logic [11:0] DTBX_OFF_CMD = 12'h000;
	localparam logic [11:0] DTBX_OFF_ARG = 12'h004;
	localparam logic [11:0] DTBX_OFF_STAT = 12'h008;
	localparam logic [11:0] DTBX_OFF_FLAGS = 12'h00c;
	localparam logic [11:0] DTBX_OFF_PAGE = 12'h010;
	localparam logic [11:0] DTBX_OFF_SP = 12'h014;
	localparam logic [11:0] DTBX_OFF_RSEL = 12'h018;
	localparam logic [11:0] DTBX_OFF_RDATA = 12'h01c;
	localparam int DTBX_CMD_OP_LSB = 0;
	localparam int DTBX_CMD_RD_LSB = 8;
	localparam int DTBX_CMD_RR_LSB = 16;
	localparam int DTBX_CMD_BIT_LSB = 24;
	localparam int DTBX_CMD_PTR_LSB = 28;
	localparam int DTBX_STAT_BUSY = 0;
	localparam int DTBX_STAT_DONE = 1;
	localparam int DTBX_STAT_FLG_LSB = 8;
	localparam int DTBX_FLG_C = 0;
	localparam int DTBX_FLG_Z = 1;
	localparam int DTBX_FLG_N = 2;
	localparam int DTBX_FLG_V = 3;
	localparam int DTBX_FLG_T = 6;
	localparam logic [4:0] DTBX_R0 = 5'h00;
	localparam logic [4:0] DTBX_PTR_X = 5'h1a;
	localparam logic [4:0] DTBX_PTR_Y = 5'h1c;
	localparam logic [4:0] DTBX_PTR_Z = 5'h1e;
	localparam logic [15:0] DTBX_SP_RST = 16'h0fff;
	localparam logic [7:0] DTBX_FLAGS_RST = 8'h00;
	localparam logic [1:0] DTBX_CYC_ONE = 2'h1;
	localparam logic [1:0] DTBX_CYC_TWO = 2'h2;
	localparam logic [1:0] DTBX_CYC_PROG = 2'h3;

	typedef enum logic [5:0] {
		OP_NOP = 6'h00,
		OP_REGISTER_COPY = 6'h01,
		OP_IMMEDIATE_LOAD = 6'h02,
		OP_PORT_READ = 6'h03,
		OP_PORT_WRITE = 6'h04,
		OP_INDIRECT_LOAD = 6'h05,
		OP_INDIRECT_LOAD_INC = 6'h06,
		OP_INDIRECT_LOAD_DEC = 6'h07,
		OP_OFFSET_LOAD = 6'h08,
		OP_ABSOLUTE_LOAD = 6'h09,
		OP_INDIRECT_WRITE = 6'h0a,
		OP_INDIRECT_WRITE_INC = 6'h0b,
		OP_INDIRECT_WRITE_DEC = 6'h0c,
		OP_OFFSET_WRITE = 6'h0d,
		OP_ABSOLUTE_WRITE = 6'h0e,
		OP_PROGRAM_MEMORY_READ = 6'h0f,
		OP_EXTENDED_PROGRAM_READ = 6'h10,
		OP_STACK_PUSH = 6'h11,
		OP_STACK_POP = 6'h12,
		OP_IO_BIT_SET = 6'h13,
		OP_IO_BIT_CLEAR = 6'h14,
		OP_LOGICAL_LEFT_SHIFT = 6'h15,
		OP_LOGICAL_RIGHT_SHIFT = 6'h16,
		OP_ROTATE_LEFT_CARRY = 6'h17,
		OP_ROTATE_RIGHT_CARRY = 6'h18,
		OP_SIGNED_RIGHT_SHIFT = 6'h19,
		OP_NIBBLE_SWAP = 6'h1a,
		OP_BIT_TO_TRANSFER_FLAG = 6'h1b,
		OP_TRANSFER_FLAG_TO_BIT = 6'h1c,
		OP_FLAG_INDEX_SET = 6'h1d,
		OP_FLAG_INDEX_CLEAR = 6'h1e,
		OP_CARRY_SET = 6'h1f,
		OP_CARRY_CLEAR = 6'h20,
		OP_NEGATIVE_SET = 6'h21,
		OP_NEGATIVE_CLEAR = 6'h22
	} dtbx_op_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_C1 = 2'b01,
		ST_C2 = 2'b10,
		ST_C3 = 2'b11
	} dtbx_state_t;

	function automatic logic dtbx_is_load(dtbx_op_t op);
		return op inside {OP_INDIRECT_LOAD, OP_INDIRECT_LOAD_INC, OP_INDIRECT_LOAD_DEC,
			OP_OFFSET_LOAD, OP_ABSOLUTE_LOAD, OP_STACK_POP};
	endfunction

	function automatic logic dtbx_is_store(dtbx_op_t op);
		return op inside {OP_INDIRECT_WRITE, OP_INDIRECT_WRITE_INC, OP_INDIRECT_WRITE_DEC,
			OP_OFFSET_WRITE, OP_ABSOLUTE_WRITE, OP_STACK_PUSH};
	endfunction

	function automatic logic dtbx_is_prog(dtbx_op_t op);
		return op inside {OP_PROGRAM_MEMORY_READ, OP_EXTENDED_PROGRAM_READ};
	endfunction

	function automatic logic dtbx_is_iobit(dtbx_op_t op);
		return op inside {OP_IO_BIT_SET, OP_IO_BIT_CLEAR};
	endfunction

	function automatic logic [1:0] dtbx_cycles(dtbx_op_t op);
		if (dtbx_is_prog(op)) begin
			return DTBX_CYC_PROG;
		end
		if (dtbx_is_load(op) || dtbx_is_store(op) || dtbx_is_iobit(op)) begin
			return DTBX_CYC_TWO;
		end
		return DTBX_CYC_ONE;
	endfunction

	function automatic logic [4:0] dtbx_ptr_base(logic [1:0] sel);
		case (sel)
			2'h0: return DTBX_PTR_X;
			2'h1: return DTBX_PTR_Y;
			default: return DTBX_PTR_Z;
		endcase
	endfunction

	function automatic logic dtbx_mapped(logic [11:0] a);
		return a inside {DTBX_OFF_CMD, DTBX_OFF_ARG, DTBX_OFF_STAT, DTBX_OFF_FLAGS,
			DTBX_OFF_PAGE, DTBX_OFF_SP, DTBX_OFF_RSEL, DTBX_OFF_RDATA};
	endfunction
endpackage

//--- dtbx_addr_unit.sv
`timescale 1ns/1ps
module dtbx_addr_unit
	import dtbx_pkg::*;
(
	input wire dtbx_op_t op,
	input wire logic [15:0] ptr,
	input wire logic [5:0] disp,
	input wire logic [15:0] abs_addr,
	input wire logic [15:0] sp,
	output logic [15:0] eff_addr,
	output logic [15:0] ptr_nxt,
	output logic [15:0] sp_nxt
);
	always_comb begin
		eff_addr = ptr;
		ptr_nxt = ptr;
		sp_nxt = sp;
		case (op)
			OP_INDIRECT_LOAD_INC, OP_INDIRECT_WRITE_INC: begin
				ptr_nxt = ptr + 16'h0001;
			end
			OP_INDIRECT_LOAD_DEC, OP_INDIRECT_WRITE_DEC: begin
				eff_addr = ptr - 16'h0001;
				ptr_nxt = ptr - 16'h0001;
			end
			OP_OFFSET_LOAD, OP_OFFSET_WRITE: begin
				eff_addr = ptr + {10'h000, disp};
			end
			OP_ABSOLUTE_LOAD, OP_ABSOLUTE_WRITE: begin
				eff_addr = abs_addr;
			end
			OP_STACK_PUSH: begin
				eff_addr = sp;
				sp_nxt = sp - 16'h0001;
			end
			OP_STACK_POP: begin
				eff_addr = sp + 16'h0001;
				sp_nxt = sp + 16'h0001;
			end
			default: begin
				eff_addr = ptr;
			end
		endcase
	end
endmodule

//--- dtbx_bit_unit.sv
`timescale 1ns/1ps
module dtbx_bit_unit
	import dtbx_pkg::*;
(
	input wire dtbx_op_t op,
	input wire logic [7:0] operand,
	input wire logic [7:0] flags,
	input wire logic [2:0] bit_sel,
	output logic [7:0] result,
	output logic [7:0] flags_out
);
	logic carry;
	logic shift_op;

	always_comb begin
		result = operand;
		flags_out = flags;
		carry = flags[DTBX_FLG_C];
		shift_op = 1'b1;
		case (op)
			OP_LOGICAL_LEFT_SHIFT: begin
				result = {operand[6:0], 1'b0};
				carry = operand[7];
			end
			OP_LOGICAL_RIGHT_SHIFT: begin
				result = {1'b0, operand[7:1]};
				carry = operand[0];
			end
			OP_ROTATE_LEFT_CARRY: begin
				result = {operand[6:0], flags[DTBX_FLG_C]};
				carry = operand[7];
			end
			OP_ROTATE_RIGHT_CARRY: begin
				result = {flags[DTBX_FLG_C], operand[7:1]};
				carry = operand[0];
			end
			OP_SIGNED_RIGHT_SHIFT: begin
				result = {operand[7], operand[7:1]};
				carry = operand[0];
			end
			default: begin
				shift_op = 1'b0;
			end
		endcase
		if (shift_op) begin
			flags_out[DTBX_FLG_C] = carry;
			flags_out[DTBX_FLG_Z] = (result == 8'h00);
			flags_out[DTBX_FLG_N] = result[7];
			flags_out[DTBX_FLG_V] = result[7] ^ carry;
		end
		case (op)
			OP_NIBBLE_SWAP: begin
				result = {operand[3:0], operand[7:4]};
			end
			OP_BIT_TO_TRANSFER_FLAG: begin
				flags_out[DTBX_FLG_T] = operand[bit_sel];
			end
			OP_TRANSFER_FLAG_TO_BIT: begin
				result[bit_sel] = flags[DTBX_FLG_T];
			end
			OP_FLAG_INDEX_SET: begin
				flags_out[bit_sel] = 1'b1;
			end
			OP_FLAG_INDEX_CLEAR: begin
				flags_out[bit_sel] = 1'b0;
			end
			OP_CARRY_SET: begin
				flags_out[DTBX_FLG_C] = 1'b1;
			end
			OP_CARRY_CLEAR: begin
				flags_out[DTBX_FLG_C] = 1'b0;
			end
			OP_NEGATIVE_SET: begin
				flags_out[DTBX_FLG_N] = 1'b1;
			end
			OP_NEGATIVE_CLEAR: begin
				flags_out[DTBX_FLG_N] = 1'b0;
			end
			default: begin
				result = result;
			end
		endcase
	end
endmodule

//--- dtbx_exec.sv
`timescale 1ns/1ps
module dtbx_exec
	import dtbx_pkg::*;
#(
	parameter int PAGE_W = 1
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	output logic [15:0] dmem_addr,
	output logic [7:0] dmem_wdata,
	output logic dmem_re,
	output logic dmem_we,
	input wire logic [7:0] dmem_rdata,
	output logic [5:0] io_addr,
	output logic [7:0] io_wdata,
	output logic io_re,
	output logic io_we,
	input wire logic [7:0] io_rdata,
	output logic [PAGE_W+15:0] pmem_addr,
	output logic pmem_re,
	input wire logic [7:0] pmem_rdata
);
	dtbx_state_t state_r;
	dtbx_op_t op_r;
	logic [4:0] rd_r;
	logic [4:0] rr_r;
	logic [2:0] bit_r;
	logic [1:0] psel_r;
	logic [15:0] arg_r;
	logic [PAGE_W-1:0] page_r;
	logic [15:0] sp_r;
	logic [7:0] flags_r;
	logic done_r;
	logic [4:0] regsel_r;
	logic [7:0] io_tmp_r;
	logic [31:0] prdata_r;
	logic [7:0] rf [32];

	logic apb_setup;
	logic apb_wr;
	logic busy;
	logic start;
	logic last;
	logic [1:0] cyc;
	logic [4:0] pidx;
	logic [4:0] pidx_hi;
	logic [15:0] ptr;
	logic [15:0] zptr;
	logic [7:0] rd_val;
	logic [7:0] rr_val;
	logic [7:0] bit_mask;
	logic [15:0] eff_addr;
	logic [15:0] ptr_nxt;
	logic [15:0] sp_nxt;
	logic [7:0] alu_res;
	logic [7:0] alu_flags;
	logic ptr_upd;

	assign apb_setup = psel && !penable;
	assign apb_wr = psel && penable && pwrite;
	assign busy = (state_r != ST_IDLE);
	assign start = apb_wr && (paddr == DTBX_OFF_CMD) && !busy;
	assign cyc = dtbx_cycles(op_r);
	assign last = ((state_r == ST_C1) && (cyc == DTBX_CYC_ONE)) ||
		((state_r == ST_C2) && (cyc == DTBX_CYC_TWO)) || (state_r == ST_C3);
	assign pidx = dtbx_ptr_base(psel_r);
	assign pidx_hi = pidx + 5'h01;
	assign ptr = {rf[pidx_hi], rf[pidx]};
	assign zptr = {rf[DTBX_PTR_Z + 5'h01], rf[DTBX_PTR_Z]};
	assign rd_val = rf[rd_r];
	assign rr_val = rf[rr_r];
	assign bit_mask = 8'h01 << bit_r;
	assign ptr_upd = (state_r == ST_C1) && (op_r inside {OP_INDIRECT_LOAD_INC,
		OP_INDIRECT_LOAD_DEC, OP_INDIRECT_WRITE_INC, OP_INDIRECT_WRITE_DEC});

	dtbx_addr_unit u_addr (
		.op(op_r),
		.ptr(ptr),
		.disp(arg_r[5:0]),
		.abs_addr(arg_r),
		.sp(sp_r),
		.eff_addr(eff_addr),
		.ptr_nxt(ptr_nxt),
		.sp_nxt(sp_nxt)
	);

	dtbx_bit_unit u_bit (
		.op(op_r),
		.operand((op_r == OP_BIT_TO_TRANSFER_FLAG) ? rr_val : rd_val),
		.flags(flags_r),
		.bit_sel(bit_r),
		.result(alu_res),
		.flags_out(alu_flags)
	);

	// sequencing of execute cycles
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= ST_IDLE;
		end else begin
			case (state_r)
				ST_IDLE: state_r <= start ? ST_C1 : ST_IDLE;
				ST_C1: state_r <= last ? ST_IDLE : ST_C2;
				ST_C2: state_r <= last ? ST_IDLE : ST_C3;
				ST_C3: state_r <= ST_IDLE;
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	// command capture
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			op_r <= OP_NOP;
			rd_r <= 5'h00;
			rr_r <= 5'h00;
			bit_r <= 3'h0;
			psel_r <= 2'h0;
		end else if (start) begin
			op_r <= dtbx_op_t'(pwdata[DTBX_CMD_OP_LSB +: 6]);
			rd_r <= pwdata[DTBX_CMD_RD_LSB +: 5];
			rr_r <= pwdata[DTBX_CMD_RR_LSB +: 5];
			bit_r <= pwdata[DTBX_CMD_BIT_LSB +: 3];
			psel_r <= pwdata[DTBX_CMD_PTR_LSB +: 2];
		end
	end

	// software configuration registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			arg_r <= 16'h0000;
			page_r <= '0;
			regsel_r <= 5'h00;
		end else if (apb_wr && !busy) begin
			case (paddr)
				DTBX_OFF_ARG: arg_r <= pwdata[15:0];
				DTBX_OFF_PAGE: page_r <= pwdata[PAGE_W-1:0];
				DTBX_OFF_RSEL: regsel_r <= pwdata[4:0];
				default: arg_r <= arg_r;
			endcase
		end
	end

	// stack pointer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sp_r <= DTBX_SP_RST;
		end else if ((state_r == ST_C1) && (op_r inside {OP_STACK_PUSH, OP_STACK_POP})) begin
			sp_r <= sp_nxt;
		end else if (apb_wr && !busy && (paddr == DTBX_OFF_SP)) begin
			sp_r <= pwdata[15:0];
		end
	end

	// flag register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags_r <= DTBX_FLAGS_RST;
		end else if (state_r == ST_C1) begin
			flags_r <= alu_flags;
		end else if (apb_wr && !busy && (paddr == DTBX_OFF_FLAGS)) begin
			flags_r <= pwdata[7:0];
		end
	end

	// completion flag, set wins over clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			done_r <= 1'b0;
		end else if (last) begin
			done_r <= 1'b1;
		end else if (apb_wr && (paddr == DTBX_OFF_STAT) && pwdata[DTBX_STAT_DONE]) begin
			done_r <= 1'b0;
		end
	end

	// io byte captured for read-modify-write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			io_tmp_r <= 8'h00;
		end else if ((state_r == ST_C1) && dtbx_is_iobit(op_r)) begin
			io_tmp_r <= io_rdata;
		end
	end

	// register file
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < 32; i++) begin
				rf[i] <= 8'h00;
			end
		end else begin
			if (apb_wr && !busy && (paddr == DTBX_OFF_RDATA)) begin
				rf[regsel_r] <= pwdata[7:0];
			end
			if (ptr_upd) begin
				rf[pidx] <= ptr_nxt[7:0];
				rf[pidx_hi] <= ptr_nxt[15:8];
			end
			if (state_r == ST_C1) begin
				case (op_r)
					OP_REGISTER_COPY: rf[rd_r] <= rr_val;
					OP_IMMEDIATE_LOAD: rf[rd_r] <= arg_r[7:0];
					OP_PORT_READ: rf[rd_r] <= io_rdata;
					OP_LOGICAL_LEFT_SHIFT, OP_LOGICAL_RIGHT_SHIFT, OP_ROTATE_LEFT_CARRY,
					OP_ROTATE_RIGHT_CARRY, OP_SIGNED_RIGHT_SHIFT, OP_NIBBLE_SWAP,
					OP_TRANSFER_FLAG_TO_BIT: rf[rd_r] <= alu_res;
					default: ;
				endcase
			end
			if ((state_r == ST_C2) && dtbx_is_load(op_r)) begin
				rf[rd_r] <= dmem_rdata;
			end
			if ((state_r == ST_C3) && dtbx_is_prog(op_r)) begin
				rf[DTBX_R0] <= pmem_rdata;
			end
		end
	end

	// apb read data captured in setup phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r <= 32'h00000000;
		end else if (apb_setup) begin
			case (paddr)
				DTBX_OFF_CMD: prdata_r <= {2'h0, psel_r, 1'b0, bit_r, 3'h0, rr_r, 3'h0, rd_r,
					2'h0, op_r};
				DTBX_OFF_ARG: prdata_r <= {16'h0000, arg_r};
				DTBX_OFF_STAT: prdata_r <= {16'h0000, flags_r, 6'h00, done_r, busy};
				DTBX_OFF_FLAGS: prdata_r <= {24'h000000, flags_r};
				DTBX_OFF_PAGE: prdata_r <= 32'(page_r);
				DTBX_OFF_SP: prdata_r <= {16'h0000, sp_r};
				DTBX_OFF_RSEL: prdata_r <= {27'h0000000, regsel_r};
				DTBX_OFF_RDATA: prdata_r <= {24'h000000, rf[regsel_r]};
				default: prdata_r <= 32'h00000000;
			endcase
		end
	end

	assign pready = 1'b1;
	assign prdata = prdata_r;
	assign pslverr = psel && penable && !dtbx_mapped(paddr);

	assign dmem_re = (state_r == ST_C1) && dtbx_is_load(op_r);
	assign dmem_we = (state_r == ST_C1) && dtbx_is_store(op_r);
	assign dmem_addr = eff_addr;
	assign dmem_wdata = rr_val;

	assign io_addr = arg_r[5:0];
	assign io_re = (state_r == ST_C1) && (dtbx_is_iobit(op_r) || (op_r == OP_PORT_READ));
	assign io_we = ((state_r == ST_C1) && (op_r == OP_PORT_WRITE)) ||
		((state_r == ST_C2) && dtbx_is_iobit(op_r));
	assign io_wdata = (op_r == OP_IO_BIT_SET) ? (io_tmp_r | bit_mask) :
		(op_r == OP_IO_BIT_CLEAR) ? (io_tmp_r & ~bit_mask) : rr_val;

	// page extension over the third pointer
	assign pmem_re = (state_r == ST_C1) && dtbx_is_prog(op_r);
	assign pmem_addr = (op_r == OP_EXTENDED_PROGRAM_READ) ? {page_r, zptr} :
		{{PAGE_W{1'b0}}, zptr};

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence seq_run1;
		busy ##1 !busy;
	endsequence
	sequence seq_run2;
		busy [*2] ##1 !busy;
	endsequence
	sequence seq_run3;
		busy [*3] ##1 !busy;
	endsequence

	AST_PROG_THREE: assert property (
		start && dtbx_is_prog(dtbx_op_t'(pwdata[5:0])) |=> seq_run3 ##0 done_r)
		else $error("program read not three cycles");
	AST_PROG_ADDR: assert property (
		pmem_re && (op_r == OP_EXTENDED_PROGRAM_READ) |-> pmem_addr == {page_r, zptr}
			##3 rf[DTBX_R0] == $past(pmem_rdata))
		else $error("program byte not in r0");
	AST_MEM_TWO: assert property (
		start && (dtbx_is_load(dtbx_op_t'(pwdata[5:0])) ||
			dtbx_is_store(dtbx_op_t'(pwdata[5:0]))) |=> seq_run2)
		else $error("memory access not two cycles");
	AST_POSTINC: assert property (
		dmem_re && (op_r == OP_INDIRECT_LOAD_INC) |-> dmem_addr == ptr ##1 ptr == $past(ptr) + 16'h0001)
		else $error("post increment wrong");
	AST_PREDEC: assert property (
		dmem_we && (op_r == OP_INDIRECT_WRITE_DEC) |-> dmem_addr == ptr - 16'h0001
			##1 ptr == $past(ptr) - 16'h0001)
		else $error("pre decrement wrong");
	AST_OFFSET_KEEP: assert property (
		dmem_re && (op_r == OP_OFFSET_LOAD) |-> dmem_addr == ptr + {10'h000, arg_r[5:0]}
			##1 $stable(ptr))
		else $error("offset access moved pointer");
	AST_LOAD_DATA: assert property (
		dmem_re && (op_r == OP_ABSOLUTE_LOAD) |=> ##1 rf[rd_r] == $past(dmem_rdata))
		else $error("loaded byte not written");
	AST_FLAGS_KEPT: assert property (
		(state_r == ST_C1) && (dtbx_is_load(op_r) || dtbx_is_store(op_r) ||
			op_r inside {OP_REGISTER_COPY, OP_IMMEDIATE_LOAD, OP_PORT_READ, OP_PORT_WRITE})
			|=> $stable(flags_r))
		else $error("transfer changed flags");
	AST_IOBIT_SET: assert property (
		io_we && (state_r == ST_C2) && (op_r == OP_IO_BIT_SET) |->
			io_wdata == ($past(io_rdata) | bit_mask))
		else $error("io bit set wrong");
	AST_IOBIT_CLEAR: assert property (
		io_we && (state_r == ST_C2) && (op_r == OP_IO_BIT_CLEAR) |->
			io_wdata == ($past(io_rdata) & ~bit_mask))
		else $error("io bit clear wrong");
	AST_ROTATE_LEFT: assert property (
		(state_r == ST_C1) && (op_r == OP_ROTATE_LEFT_CARRY) |-> seq_run1 ##0
			(rd_val == {$past(rd_val[6:0]), $past(flags_r[DTBX_FLG_C])} &&
			flags_r[DTBX_FLG_C] == $past(rd_val[7])))
		else $error("rotate left wrong");
	AST_ROTATE_RIGHT: assert property (
		(state_r == ST_C1) && (op_r == OP_ROTATE_RIGHT_CARRY) |-> seq_run1 ##0
			(rd_val == {$past(flags_r[DTBX_FLG_C]), $past(rd_val[7:1])} &&
			flags_r[DTBX_FLG_C] == $past(rd_val[0])))
		else $error("rotate right wrong");
	AST_BIT_TO_T: assert property (
		(state_r == ST_C1) && (op_r == OP_BIT_TO_TRANSFER_FLAG) |=>
			flags_r[DTBX_FLG_T] == $past(rr_val[bit_r]) && !busy)
		else $error("transfer flag wrong");
endmodule

//--- dtbx_mem_model.sv
`timescale 1ns/1ps
module dtbx_mem_model #(
	parameter int PAGE_W = 1
)
(
	input wire logic pclk,
	input wire logic [15:0] dmem_addr,
	input wire logic [7:0] dmem_wdata,
	input wire logic dmem_re,
	input wire logic dmem_we,
	output logic [7:0] dmem_rdata,
	input wire logic [5:0] io_addr,
	input wire logic [7:0] io_wdata,
	input wire logic io_re,
	input wire logic io_we,
	output logic [7:0] io_rdata,
	input wire logic [PAGE_W+15:0] pmem_addr,
	input wire logic pmem_re,
	output logic [7:0] pmem_rdata
);
	logic [7:0] dmem [0:65535];
	logic [7:0] io_mem [0:63];
	logic [7:0] cyc;
	logic pv;
	logic [7:0] pd;
	// program bytes follow a fixed pattern of the address
	function automatic logic [7:0] pval(logic [PAGE_W+15:0] a);
		return a[7:0] ^ a[15:8] ^ {7'h00, a[16]};
	endfunction
	initial begin
		cyc = 8'h00;
		pv = 1'b0;
		pd = 8'h00;
		dmem_rdata = 8'h00;
		pmem_rdata = 8'h00;
	end
	// data lines hold good values only in their one valid cycle
	assign io_rdata = io_re ? io_mem[io_addr] : cyc;
	always @(posedge pclk) begin
		cyc <= cyc + 8'h01;
		if (dmem_we)
			dmem[dmem_addr] <= dmem_wdata;
		if (io_we)
			io_mem[io_addr] <= io_wdata;
		dmem_rdata <= dmem_re ? dmem[dmem_addr] : ~dmem_rdata;
		pv <= pmem_re;
		pd <= pmem_re ? pval(pmem_addr) : ~pd;
		pmem_rdata <= pv ? pd : ~pmem_rdata;
	end
endmodule

//--- dtbx_exec_tb_top.sv
`timescale 1ns/1ps
module dtbx_exec_tb_top
	import dtbx_pkg::*;
;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic dmem_re, dmem_we, io_re, io_we, pmem_re;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [15:0] dmem_addr;
	logic [7:0] dmem_wdata, dmem_rdata, io_wdata, io_rdata, pmem_rdata;
	logic [5:0] io_addr;
	logic [16:0] pmem_addr;
	int mismatches = 0;
	int cmp_count = 0;
	int nstrb = 0;
	dtbx_exec #(.PAGE_W(1)) dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .pready, .prdata, .pslverr, .dmem_addr, .dmem_wdata, .dmem_re,
		.dmem_we, .dmem_rdata, .io_addr, .io_wdata, .io_re, .io_we, .io_rdata,
		.pmem_addr, .pmem_re, .pmem_rdata);
	dtbx_mem_model #(.PAGE_W(1)) u_mem (.pclk, .dmem_addr, .dmem_wdata, .dmem_re,
		.dmem_we, .dmem_rdata, .io_addr, .io_wdata, .io_re, .io_we, .io_rdata,
		.pmem_addr, .pmem_re, .pmem_rdata);
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	always @(posedge pclk)
		nstrb <= nstrb + int'(dmem_re) + int'(dmem_we);
	task automatic wrap_up();
		$display("compares %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		cmp_count++;
		if (g !== x) begin
			mismatches++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, x);
		end
	endtask
	task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (pready !== 1'b1) begin
			mismatches++;
			wrap_up();
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		xfer(a, 1'b1, d, r, e);
	endtask
	task automatic rd(input logic [11:0] a, output logic [31:0] r);
		logic e;
		xfer(a, 1'b0, 32'h0, r, e);
	endtask
	task automatic set_reg(input logic [4:0] i, input logic [7:0] v);
		wr(DTBX_OFF_RSEL, {27'h0, i});
		wr(DTBX_OFF_RDATA, {24'h0, v});
	endtask
	task automatic get_reg(input logic [4:0] i, output logic [7:0] v);
		logic [31:0] r;
		wr(DTBX_OFF_RSEL, {27'h0, i});
		rd(DTBX_OFF_RDATA, r);
		v = r[7:0];
	endtask
	task automatic issue(input dtbx_op_t op, input logic [4:0] d, input logic [4:0] s,
		input logic [2:0] b, input logic [1:0] p, input logic [15:0] a);
		wr(DTBX_OFF_ARG, {16'h0, a});
		wr(DTBX_OFF_CMD, {2'b0, p, 1'b0, b, 3'b0, s, 3'b0, d, 2'b0, op});
	endtask
	task automatic wait_idle();
		logic [31:0] s;
		int n;
		n = 0;
		do begin
			rd(DTBX_OFF_STAT, s);
			n++;
		end while (s[DTBX_STAT_BUSY] !== 1'b0 && n < 8);
		if (s[DTBX_STAT_BUSY] !== 1'b0) begin
			mismatches++;
			wrap_up();
		end
		chk({31'h0, s[DTBX_STAT_DONE]}, 32'h1);
		wr(DTBX_OFF_STAT, 32'h2);
	endtask
	task automatic exec(input dtbx_op_t op, input logic [4:0] d, input logic [4:0] s,
		input logic [2:0] b, input logic [1:0] p, input logic [15:0] a);
		issue(op, d, s, b, p, a);
		wait_idle();
	endtask
	task automatic t_reset();
		logic [31:0] r;
		logic e;
		rd(DTBX_OFF_FLAGS, r);
		chk(r, 32'h0);
		rd(DTBX_OFF_SP, r);
		chk(r, 32'h0fff);
		xfer(12'h020, 1'b0, 32'h0, r, e);
		chk({31'h0, e}, 32'h1);
		chk(r, 32'h0);
		$display("reset test done");
	endtask
	task automatic t_mem();
		logic [79:0] tbl [10] = '{80'h06_00_0100_0000_0100_0101, 80'h07_01_0200_0000_01ff_01ff,
			80'h08_02_0300_0005_0305_0300, 80'h09_02_0300_0456_0456_0300,
			80'h0b_01_0500_0000_0500_0501, 80'h0c_02_0600_0000_05ff_05ff,
			80'h0d_01_0700_003f_073f_0700, 80'h0e_00_0100_0abc_0abc_0100,
			80'h05_00_0800_0000_0800_0800, 80'h0a_01_0900_0000_0900_0900};
		logic [7:0] o8, p8, v, lo, hi;
		logic [15:0] pi, a, eff, pa;
		logic [4:0] base;
		logic [31:0] r;
		logic st;
		int s0;
		wr(DTBX_OFF_FLAGS, 32'h55);
		for (int i = 0; i < 10; i++) begin
			{o8, p8, pi, a, eff, pa} = tbl[i];
			st = (o8 >= 8'h0a);
			base = 5'h1a + {2'b0, p8[1:0], 1'b0};
			v = 8'ha0 + 8'(i);
			set_reg(base, pi[7:0]);
			set_reg(base + 5'h01, pi[15:8]);
			if (st)
				set_reg(5'h02, v);
			else
				u_mem.dmem[eff] = v;
			s0 = nstrb;
			exec(dtbx_op_t'(o8[5:0]), 5'h01, 5'h02, 3'h0, p8[1:0], a);
			chk(32'(nstrb - s0), 32'h1);
			if (st)
				chk({24'h0, u_mem.dmem[eff]}, {24'h0, v});
			else begin
				get_reg(5'h01, lo);
				chk({24'h0, lo}, {24'h0, v});
			end
			get_reg(base, lo);
			get_reg(base + 5'h01, hi);
			chk({16'h0, hi, lo}, {16'h0, pa});
		end
		rd(DTBX_OFF_FLAGS, r);
		chk(r, 32'h55);
		$display("memory test done");
	endtask
	task automatic t_stack_io();
		logic [31:0] r;
		logic [7:0] v;
		set_reg(5'h03, 8'h3c);
		exec(OP_STACK_PUSH, 5'h03, 5'h03, 3'h0, 2'h0, 16'h0);
		chk({24'h0, u_mem.dmem[16'h0fff]}, 32'h3c);
		rd(DTBX_OFF_SP, r);
		chk(r, 32'h0ffe);
		exec(OP_STACK_POP, 5'h04, 5'h04, 3'h0, 2'h0, 16'h0);
		get_reg(5'h04, v);
		chk({24'h0, v}, 32'h3c);
		rd(DTBX_OFF_SP, r);
		chk(r, 32'h0fff);
		u_mem.io_mem[5] = 8'h81;
		exec(OP_IO_BIT_SET, 5'h00, 5'h00, 3'h3, 2'h0, 16'h0005);
		chk({24'h0, u_mem.io_mem[5]}, 32'h89);
		exec(OP_IO_BIT_CLEAR, 5'h00, 5'h00, 3'h7, 2'h0, 16'h0005);
		chk({24'h0, u_mem.io_mem[5]}, 32'h09);
		$display("stack and io test done");
	endtask
	task automatic t_prog();
		logic [31:0] f, r;
		logic [7:0] v;
		wr(DTBX_OFF_PAGE, 32'h1);
		set_reg(5'h1e, 8'h34);
		set_reg(5'h1f, 8'h12);
		rd(DTBX_OFF_FLAGS, f);
		issue(OP_EXTENDED_PROGRAM_READ, 5'h00, 5'h00, 3'h0, 2'h2, 16'h0);
		wr(DTBX_OFF_FLAGS, 32'hff);
		wait_idle();
		get_reg(5'h00, v);
		chk({24'h0, v}, {24'h0, 8'h34 ^ 8'h12 ^ 8'h01});
		rd(DTBX_OFF_FLAGS, r);
		chk(r, f);
		exec(OP_PROGRAM_MEMORY_READ, 5'h00, 5'h00, 3'h0, 2'h2, 16'h0);
		get_reg(5'h00, v);
		chk({24'h0, v}, {24'h0, 8'h34 ^ 8'h12});
		$display("program read test done");
	endtask
	task automatic t_shift();
		dtbx_op_t op;
		logic [7:0] x, res, f0, fx, g;
		logic c;
		logic [31:0] r;
		for (int k = 0; k < 12; k++) begin
			op = dtbx_op_t'(6'h15 + 6'(k / 2));
			x = (k % 2) ? 8'h01 : 8'h81;
			c = (k % 2) == 0;
			f0 = {7'h18, c};
			set_reg(5'h0a, x);
			wr(DTBX_OFF_FLAGS, {24'h0, f0});
			case (op)
				OP_LOGICAL_LEFT_SHIFT: {c, res} = {x, 1'b0};
				OP_LOGICAL_RIGHT_SHIFT: {res, c} = {1'b0, x};
				OP_ROTATE_LEFT_CARRY: {c, res} = {x, c};
				OP_ROTATE_RIGHT_CARRY: {res, c} = {c, x};
				OP_SIGNED_RIGHT_SHIFT: {res, c} = {x[7], x};
				default: res = {x[3:0], x[7:4]};
			endcase
			fx = (op == OP_NIBBLE_SWAP) ? f0 : {f0[7:4], res[7] ^ c, res[7], res == 8'h00, c};
			exec(op, 5'h0a, 5'h0a, 3'h0, 2'h0, 16'h0);
			get_reg(5'h0a, g);
			chk({24'h0, g}, {24'h0, res});
			rd(DTBX_OFF_FLAGS, r);
			chk(r, {24'h0, fx});
		end
		$display("shift test done");
	endtask
	task automatic t_flags();
		logic [23:0] ft [6] = '{24'h1d0450, 24'h1e0610, 24'h1f0011, 24'h210015,
			24'h200014, 24'h220010};
		logic [31:0] r;
		logic [7:0] v;
		wr(DTBX_OFF_FLAGS, 32'h0);
		set_reg(5'h05, 8'h40);
		set_reg(5'h06, 8'h81);
		exec(OP_BIT_TO_TRANSFER_FLAG, 5'h05, 5'h05, 3'h6, 2'h0, 16'h0);
		rd(DTBX_OFF_FLAGS, r);
		chk(r, 32'h40);
		exec(OP_TRANSFER_FLAG_TO_BIT, 5'h06, 5'h06, 3'h2, 2'h0, 16'h0);
		get_reg(5'h06, v);
		chk({24'h0, v}, 32'h85);
		for (int j = 0; j < 6; j++) begin
			exec(dtbx_op_t'(ft[j][21:16]), 5'h00, 5'h00, ft[j][10:8], 2'h0, 16'h0);
			rd(DTBX_OFF_FLAGS, r);
			chk(r, {24'h0, ft[j][7:0]});
		end
		$display("flag test done");
	endtask
	task automatic t_misc();
		logic [31:0] r;
		logic [7:0] v;
		wr(DTBX_OFF_FLAGS, 32'h5a);
		u_mem.io_mem[7] = 8'hc3;
		exec(OP_REGISTER_COPY, 5'h07, 5'h05, 3'h0, 2'h0, 16'h0);
		get_reg(5'h07, v);
		chk({24'h0, v}, 32'h40);
		exec(OP_IMMEDIATE_LOAD, 5'h08, 5'h08, 3'h0, 2'h0, 16'h009e);
		get_reg(5'h08, v);
		chk({24'h0, v}, 32'h9e);
		exec(OP_PORT_READ, 5'h09, 5'h09, 3'h0, 2'h0, 16'h0007);
		get_reg(5'h09, v);
		chk({24'h0, v}, 32'hc3);
		exec(OP_PORT_WRITE, 5'h08, 5'h08, 3'h0, 2'h0, 16'h0008);
		chk({24'h0, u_mem.io_mem[8]}, 32'h9e);
		rd(DTBX_OFF_FLAGS, r);
		chk(r, 32'h5a);
		$display("move test done");
	endtask
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_mem();
		t_stack_io();
		t_prog();
		t_shift();
		t_flags();
		t_misc();
		wrap_up();
	end
endmodule
